//--- fsb_burst_seq.sv
// synchronous burst read sequencer with apb configuration

module fsb_burst_seq #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    // system clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // burst link from host
    input  wire logic              clk_link,
    input  wire logic              address_valid_n,
    input  wire logic              chip_enable_n,
    input  wire logic              output_enable_n,
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   wait_out,
    output logic                   wait_oe,
    // flash array read port
    output logic      [ADDR_W-1:0] array_addr,
    input  wire logic [DATA_W-1:0] array_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [4:0] burst_words(input logic [2:0] code);
        case (code)
            fsb_pkg::LEN_4:  burst_words = fsb_pkg::WORDS_4;
            fsb_pkg::LEN_8:  burst_words = fsb_pkg::WORDS_8;
            fsb_pkg::LEN_16: burst_words = fsb_pkg::WORDS_16;
            default:        burst_words = 5'h00;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                    input logic [2:0]        code,
                                                    input logic              wrap_dis);
        logic [ADDR_W-1:0] r;
        r = a + {{(ADDR_W-1){1'b0}}, 1'b1};
        if (!wrap_dis)
        begin
            case (code)
                fsb_pkg::LEN_4:  r = {a[ADDR_W-1:2], 2'(a[1:0] + 2'h1)};
                fsb_pkg::LEN_8:  r = {a[ADDR_W-1:3], 3'(a[2:0] + 3'h1)};
                fsb_pkg::LEN_16: r = {a[ADDR_W-1:4], 4'(a[3:0] + 4'h1)};
                default:        r = a + {{(ADDR_W-1){1'b0}}, 1'b1};
            endcase
        end
        next_addr = r;
    endfunction

    function automatic logic [2:0] row_wait_cycles(input logic [1:0] off,
                                                   input logic [2:0] lat);
        logic [3:0] sum;
        sum = {2'h0, off} + {1'b0, lat};
        if (off == fsb_pkg::GROUP_START)
            row_wait_cycles = 3'h0;
        else if (sum > fsb_pkg::GROUP_WORDS)
            row_wait_cycles = 3'(sum - fsb_pkg::GROUP_WORDS);
        else
            row_wait_cycles = 3'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // system side: registers and apb

    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic        req_tgl_q;
    logic        req_tgl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        ack_s;
    logic        busy_s;
    logic        roww_s;
    logic        pending;
    logic        hit_cfg;
    logic        hit_stat;
    logic        err;

    assign pending  = req_tgl_q ^ ack_s;
    assign hit_cfg  = (paddr == fsb_pkg::CFG_OFS);
    assign hit_stat = (paddr == fsb_pkg::STAT_OFS);
    assign err      = !(hit_cfg || hit_stat) || (pwrite && hit_stat) || (pwrite && pending);

    always_comb
    begin
        cfg_d     = cfg_q;
        req_tgl_d = req_tgl_q;
        prdata_d  = prdata_q;
        if (psel && !penable && !pwrite)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_cfg)
                prdata_d[15:0] = cfg_q;
            if (hit_stat)
            begin
                prdata_d[fsb_pkg::STAT_PEND_BIT] = pending;
                prdata_d[fsb_pkg::STAT_BUSY_BIT] = busy_s;
                prdata_d[fsb_pkg::STAT_ROWW_BIT] = roww_s;
            end
        end
        if (psel && penable && pwrite && hit_cfg && !pending)
        begin
            cfg_d             = (pwdata[15:0] & fsb_pkg::CFG_WMASK) | (cfg_q & ~fsb_pkg::CFG_WMASK);
            cfg_d[fsb_pkg::ORDER_BIT] = 1'b1;
            req_tgl_d         = ~req_tgl_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_q     <= fsb_pkg::CFG_RESET;
            req_tgl_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            cfg_q     <= cfg_d;
            req_tgl_q <= req_tgl_d;
            prdata_q  <= prdata_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err;

    ////////////////////////////////////////////////////////////////////////////
    // link side: clock edge selection and config crossing

    logic          link_clk;
    logic          req_s;
    logic          ack_tgl_q;
    logic          ack_tgl_d;
    logic [15:0]   lcfg_q;
    logic [15:0]   lcfg_d;

    // edge bit comes from cfg_q directly, not the idle-loaded copy; an apb write changes it even during a burst
    assign link_clk = cfg_q[fsb_pkg::CE_BIT] ? clk_link : ~clk_link;

    fsb_sync #(.WIDTH(1)) u_req_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    (req_tgl_q),
        .q    (req_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side: burst sequencing

    fsb_pkg::fsb_state_type st_q;
    fsb_pkg::fsb_state_type st_d;
    logic [ADDR_W-1:0]      addr_q;
    logic [ADDR_W-1:0]      addr_d;
    logic [2:0]             cnt_q;
    logic [2:0]             cnt_d;
    logic                   hold_q;
    logic                   hold_d;
    logic [4:0]             words_q;
    logic [4:0]             words_d;
    logic [1:0]             off_q;
    logic [1:0]             off_d;
    logic                   row_done_q;
    logic                   row_done_d;
    logic                   row_seen_q;
    logic                   row_seen_d;
    logic [DATA_W-1:0]      data_q;
    logic [DATA_W-1:0]      data_d;
    logic                   wait_q;
    logic                   wait_d;
    logic                   busy_q;
    logic                   busy_d;
    logic [2:0]             lat;
    logic                   hold2;
    logic [4:0]             len;
    logic                   last_now;
    logic                   last_next;
    logic                   ahead;
    logic [ADDR_W-1:0]      nxt;
    logic [2:0]             rw;

    fsb_sync #(.WIDTH(3)) u_stat_sync (
        .clk  (clk_sys),
        .rstn (rstn),
        .d    ({row_seen_q, busy_q, ack_tgl_q}),
        .q    ({roww_s, busy_s, ack_s})
    );

    assign lat   = lcfg_q[fsb_pkg::LAT_LSB +: 3];
    assign hold2 = lcfg_q[fsb_pkg::HOLD_BIT];
    assign len   = burst_words(lcfg_q[fsb_pkg::LEN_LSB +: 3]);
    assign nxt   = next_addr(addr_q, lcfg_q[fsb_pkg::LEN_LSB +: 3], lcfg_q[fsb_pkg::WRAPDIS_BIT]);
    assign rw    = row_wait_cycles(off_q, lat);

    always_comb
    begin
        st_d       = st_q;
        addr_d     = addr_q;
        cnt_d      = cnt_q;
        hold_d     = hold_q;
        words_d    = words_q;
        off_d      = off_q;
        row_done_d = row_done_q;
        row_seen_d = row_seen_q;
        data_d     = data_q;
        ack_tgl_d  = ack_tgl_q;
        lcfg_d     = lcfg_q;
        last_now   = (len != 5'h00) ? (words_q == len) : (&addr_q);
        if (st_q == fsb_pkg::ST_IDLE && req_s != ack_tgl_q)
        begin
            lcfg_d    = cfg_q;
            ack_tgl_d = req_s;
        end
        if (chip_enable_n)
            st_d = fsb_pkg::ST_IDLE;
        else if (!address_valid_n)
        begin
            st_d       = fsb_pkg::ST_LAT;
            addr_d     = addr_in;
            cnt_d      = 3'(lat - 3'h1);
            off_d      = addr_in[1:0];
            words_d    = 5'h00;
            hold_d     = 1'b0;
            row_done_d = 1'b0;
            row_seen_d = 1'b0;
        end
        else
        begin
            case (st_q)
                fsb_pkg::ST_LAT, fsb_pkg::ST_ROW:
                begin
                    if (cnt_q == 3'h0)
                    begin
                        st_d    = fsb_pkg::ST_DATA;
                        data_d  = array_rdata;
                        hold_d  = hold2;
                        words_d = 5'(words_q + 5'h01);
                    end
                    else
                        cnt_d = 3'(cnt_q - 3'h1);
                end
                fsb_pkg::ST_DATA:
                begin
                    if (hold_q)
                        hold_d = 1'b0;
                    else if (last_now)
                        st_d = fsb_pkg::ST_END;
                    else
                    begin
                        addr_d = nxt;
                        if (lcfg_q[fsb_pkg::WRAPDIS_BIT] && !hold2 && !row_done_q
                            && nxt[3:0] == fsb_pkg::ROW_START)
                        begin
                            row_done_d = 1'b1;
                            if (rw != 3'h0)
                            begin
                                st_d       = fsb_pkg::ST_ROW;
                                cnt_d      = 3'(rw - 3'h1);
                                row_seen_d = 1'b1;
                            end
                        end
                        if (st_d == fsb_pkg::ST_DATA)
                        begin
                            data_d  = array_rdata;
                            hold_d  = hold2;
                            words_d = 5'(words_q + 5'h01);
                        end
                    end
                end
                fsb_pkg::ST_END:  st_d = fsb_pkg::ST_END;
                fsb_pkg::ST_IDLE: st_d = fsb_pkg::ST_IDLE;
                default:          st_d = fsb_pkg::ST_IDLE;
            endcase
        end
        // wait lookahead: valid data within one data cycle
        last_next = (len != 5'h00) ? (words_d == len) : (&addr_d);
        case (st_d)
            fsb_pkg::ST_LAT, fsb_pkg::ST_ROW: ahead = ({1'b0, cnt_d} < (hold2 ? 4'h2 : 4'h1));
            fsb_pkg::ST_DATA: ahead = !last_next || hold_d;
            default:          ahead = 1'b0;
        endcase
        busy_d = (st_d != fsb_pkg::ST_IDLE);
        if (st_d == fsb_pkg::ST_IDLE)
            wait_d = 1'b0;
        else if (lcfg_q[fsb_pkg::EARLY_BIT])
            wait_d = !ahead;
        else
            wait_d = (st_d != fsb_pkg::ST_DATA);
    end

    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q       <= fsb_pkg::ST_IDLE;
            addr_q     <= '0;
            cnt_q      <= 3'h0;
            hold_q     <= 1'b0;
            words_q    <= 5'h00;
            off_q      <= 2'h0;
            row_done_q <= 1'b0;
            row_seen_q <= 1'b0;
            data_q     <= '0;
            wait_q     <= 1'b0;
            busy_q     <= 1'b0;
            ack_tgl_q  <= 1'b0;
            lcfg_q     <= fsb_pkg::CFG_RESET;
        end
        else
        begin
            st_q       <= st_d;
            addr_q     <= addr_d;
            cnt_q      <= cnt_d;
            hold_q     <= hold_d;
            words_q    <= words_d;
            off_q      <= off_d;
            row_done_q <= row_done_d;
            row_seen_q <= row_seen_d;
            data_q     <= data_d;
            wait_q     <= wait_d;
            busy_q     <= busy_d;
            ack_tgl_q  <= ack_tgl_d;
            lcfg_q     <= lcfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and array port

    // array is read combinationally at the address about to be launched
    assign array_addr = addr_d;
    assign dq_out     = data_q;
    assign wait_out   = wait_q;
    assign dq_oe      = !chip_enable_n && !output_enable_n;
    assign wait_oe    = !chip_enable_n && !output_enable_n;

endmodule // fsb_burst_seq

//--- fsb_burst_seq_chk.sv
// assertion checker for the burst sequencer ports
module fsb_burst_seq_chk #(
    parameter int DATA_W = 16
) (
    // system side
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic [7:0]        paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic              pslverr,
    // link side
    input wire logic              clk_link,
    input wire logic              chip_enable_n,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              wait_out,
    input wire logic              wait_oe,
    input wire logic [DATA_W-1:0] array_rdata
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////
    // apb
    a_pready_on_access: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_unmapped_err: assert property (psel && penable && paddr != 8'h00 && paddr != 8'h04 |-> pslverr)
        else $error("unmapped access not refused");
    a_status_ro: assert property (psel && penable && pwrite && paddr == 8'h04 |-> pslverr)
        else $error("status write not refused");
    a_read_no_err: assert property (psel && penable && !pwrite && paddr[7:3] == 5'h00 && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("register read refused");

    ////////////////////////////////////////
    // link
    a_oe_from_pins: assert property ((dq_oe == (!chip_enable_n && !output_enable_n)) && wait_oe == dq_oe)
        else $error("output enables do not follow pins");
    a_launch_on_link: assert property ($changed(dq_out) || $changed(wait_out) |-> $changed(clk_link))
        else $error("link output changed without link edge");
    a_data_from_array: assert property ($changed(dq_out) |-> dq_out == $past(array_rdata))
        else $error("data word not taken from array");
    a_idle_wait_low: assert property (chip_enable_n [*8] ##1 chip_enable_n [*4] |-> !wait_out)
        else $error("wait high while deselected");
endmodule // fsb_burst_seq_chk

//--- fsb_burst_seq_tb.sv
// testbench for the burst sequencer: apb setup and burst table
module fsb_burst_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {int lat, early, ce, wdis, blen, st, nw, hold2;} fsb_case_type;
    localparam logic [15:0] DPAT = 16'h5A3C;

    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        clk_link, address_valid_n, chip_enable_n, output_enable_n;
    logic        dq_oe, wait_out, wait_oe, edge_rise;
    logic [15:0] addr_in, dq_out, array_addr, array_rdata;
    int          err_total = 0;
    int          checked = 0;
    int          ticks = 0;
    fsb_case_type tc[13] = '{'{3, 0, 1, 0, 1, 'h02, 4, 0}, '{3, 0, 1, 1, 1, 'h03, 4, 0},
        '{3, 0, 1, 0, 2, 'h05, 8, 0}, '{3, 0, 1, 0, 3, 'h1E, 16, 0}, '{3, 0, 1, 1, 3, 'hFD, 16, 0},
        '{3, 0, 1, 1, 3, 'hFE, 16, 0}, '{4, 0, 1, 1, 3, 'h0F, 16, 0}, '{5, 0, 1, 1, 3, 'h0C, 16, 0},
        '{3, 0, 1, 0, 7, 'h0E, 6, 0}, '{3, 0, 1, 1, 7, 'hFFFD, 8, 0}, '{2, 1, 1, 0, 1, 'h01, 4, 0},
        '{3, 0, 1, 1, 3, 'hFE, 16, 1}, '{3, 0, 0, 1, 1, 'h03, 4, 0}};

    assign array_rdata = array_addr ^ DPAT;

    fsb_burst_seq u_dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_link(clk_link), .address_valid_n(address_valid_n), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .addr_in(addr_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .wait_out(wait_out), .wait_oe(wait_oe), .array_addr(array_addr), .array_rdata(array_rdata));

    fsb_host_model u_host (.clk_link(clk_link), .address_valid_n(address_valid_n),
        .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .addr_in(addr_in),
        .dq_out(dq_out), .wait_out(wait_out), .edge_rise(edge_rise));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    ////////////////////////////////////////
    // tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait until the link side has taken the configuration
    task automatic settle();
        int n;
        n = 0;
        r = 32'h1;
        while (r[0] !== 1'b0 && n < 200)
        begin
            apb(fsb_pkg::STAT_OFS, 1'b0, 32'h0, r, e);
            n++;
        end
    endtask

    function automatic logic [15:0] exp_addr(fsb_case_type c, int i);
        int n;
        n = (c.blen == 1) ? 4 : (c.blen == 2) ? 8 : 16;
        if (c.blen != 7 && c.wdis == 0)
            return 16'((c.st & ~(n - 1)) + ((c.st + i) % n));
        return 16'(c.st + i);
    endfunction

    ////////////////////////////////////////
    // main sequence
    initial
    begin
        fsb_case_type c;
        int           cnt;
        int           g;
        rstn      = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        edge_rise = 1'b1;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(fsb_pkg::CFG_OFS, 1'b0, 32'h0, r, e);
        chk(r, {16'h0, fsb_pkg::CFG_RESET});
        apb(8'h08, 1'b0, 32'h0, r, e);
        chk(e, 1);
        apb(fsb_pkg::STAT_OFS, 1'b1, 32'h7, r, e);
        chk(e, 1);
        apb(fsb_pkg::CFG_OFS, 1'b1, 32'h1841, r, e);
        chk(e, 0);
        apb(fsb_pkg::CFG_OFS, 1'b1, 32'h1842, r, e);
        chk(e, 1);
        settle();
        apb(fsb_pkg::CFG_OFS, 1'b0, 32'h0, r, e);
        chk(r, 32'h18C1);
        foreach (tc[k])
        begin
            c = tc[k];
            apb(fsb_pkg::CFG_OFS, 1'b1, {18'h0, c.lat[2:0], 1'b0, c.hold2[0], c.early[0], 1'b1, c.ce[0], 2'h0,
                c.wdis[0], c.blen[2:0]}, r, e);
            settle();
            edge_rise <= c.ce[0];
            @(posedge clk_sys);
            u_host.burst(16'(c.st), c.nw, c.early[0], c.hold2[0]);
            cnt = (c.blen == 7 && 65536 - c.st < c.nw) ? 65536 - c.st : c.nw;
            g = 0;
            if (c.wdis == 1 && c.hold2 == 0 && 16 - c.st % 16 < cnt && c.st % 4 != 0 && c.st % 4 + c.lat > 4)
                g = c.st % 4 + c.lat - 4;
            chk(u_host.got.size(), cnt);
            for (int i = 0; i < u_host.got.size(); i++)
                chk(u_host.got[i], exp_addr(c, i) ^ DPAT);
            chk(u_host.first_lo, c.lat - c.early);
            chk(u_host.gaps, g);
            apb(fsb_pkg::STAT_OFS, 1'b0, 32'h0, r, e);
            chk(r[fsb_pkg::STAT_ROWW_BIT], g != 0);
        end
        give_verdict();
    end
endmodule // fsb_burst_seq_tb

bind fsb_burst_seq fsb_burst_seq_chk #(.DATA_W(DATA_W)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .clk_link(clk_link), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out),
    .wait_oe(wait_oe), .array_rdata(array_rdata));

//--- fsb_host_model.sv
// host model: burst clock, strobe, enables and word capture
module fsb_host_model (
    // burst link
    output logic            clk_link,
    output logic            address_valid_n,
    output logic            chip_enable_n,
    output logic            output_enable_n,
    output logic [15:0]     addr_in,
    input wire logic [15:0] dq_out,
    input wire logic        wait_out,
    // active edge choice
    input wire logic        edge_rise
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] got[$];
    int          gaps;
    int          first_lo;

    initial
    begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end

    initial
    begin
        address_valid_n = 1'b1;
        chip_enable_n   = 1'b1;
        output_enable_n = 1'b1;
        addr_in         = 16'h0000;
    end

    ////////////////////////////////////////
    // edge waits
    task automatic act();
        if (edge_rise)
            @(posedge clk_link);
        else
            @(negedge clk_link);
    endtask

    task automatic inact();
        if (edge_rise)
            @(negedge clk_link);
        else
            @(posedge clk_link);
    endtask

    // one burst: strobe, then collect up to nw words
    task automatic burst(input logic [15:0] a, input int nw, input logic early, input logic hold2);
        int   e;
        int   hole;
        logic pw;
        logic skip;
        got.delete();
        gaps     = 0;
        first_lo = -1;
        pw       = 1'b1;
        hole     = 0;
        skip     = 1'b0;
        inact();
        chip_enable_n   <= 1'b0;
        output_enable_n <= 1'b0;
        address_valid_n <= 1'b0;
        addr_in         <= a;
        inact();
        address_valid_n <= 1'b1;
        addr_in         <= ~a;
        for (e = 1; e < 40 && got.size() < nw; e++)
        begin
            act();
            // a two-clock data cycle is taken once; stalls count only when data follows
            if (skip)
                skip = 1'b0;
            else if (early ? pw === 1'b0 : wait_out === 1'b0)
            begin
                got.push_back(dq_out);
                gaps += hole;
                hole  = 0;
                skip  = hold2;
            end
            else if (first_lo >= 0)
                hole++;
            if (wait_out === 1'b0 && first_lo < 0)
                first_lo = e - 1;
            pw = wait_out;
        end
        inact();
        chip_enable_n   <= 1'b1;
        output_enable_n <= 1'b1;
    endtask
endmodule // fsb_host_model

//--- fsb_pkg.sv
// constants, field layout and state codes for the burst sequencer
package fsb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses on apb)
    localparam logic [7:0]  CFG_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS      = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // read_config_word field positions
    localparam int          LAT_LSB       = 11;
    localparam int          HOLD_BIT      = 9;
    localparam int          EARLY_BIT     = 8;
    localparam int          ORDER_BIT     = 7;
    localparam int          CE_BIT        = 6;
    localparam int          WRAPDIS_BIT   = 3;
    localparam int          LEN_LSB       = 0;

    // value after reset and writable bits
    localparam logic [15:0] CFG_RESET     = 16'h3BCF;
    localparam logic [15:0] CFG_WMASK     = 16'h3B4F;

    ////////////////////////////////////////////////////////////////////////////
    // status bits
    localparam int          STAT_PEND_BIT = 0;
    localparam int          STAT_BUSY_BIT = 1;
    localparam int          STAT_ROWW_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // burst_length_code values
    localparam logic [2:0]  LEN_4         = 3'h1;
    localparam logic [2:0]  LEN_8         = 3'h2;
    localparam logic [2:0]  LEN_16        = 3'h3;
    localparam logic [2:0]  LEN_CONT      = 3'h7;

    // burst word counts
    localparam logic [4:0]  WORDS_4       = 5'h04;
    localparam logic [4:0]  WORDS_8       = 5'h08;
    localparam logic [4:0]  WORDS_16      = 5'h10;

    // row is 16 words, group is 4 words
    localparam logic [3:0]  ROW_START     = 4'h0;
    localparam logic [1:0]  GROUP_START   = 2'h0;
    localparam logic [3:0]  GROUP_WORDS   = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // link state machine
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LAT  = 5'h02,
        ST_DATA = 5'h04,
        ST_ROW  = 5'h08,
        ST_END  = 5'h10
    } fsb_state_type;

endpackage

//--- fsb_sync.sv
// two flip-flop level synchroniser
module fsb_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // level in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // fsb_sync
